// *** design/cdo_pkg.sv ***
package cdo_pkg;
   // ***********************************************************
   // Opcode layout
   // ***********************************************************
   localparam int OPC_W     = 12;
   localparam int DATA_W    = 8;
   localparam int ADDR_W    = 5;
   localparam int FILE_DEPTH = 32;
   localparam int OP_HI     = 11;
   localparam int OP_LO     = 6;
   localparam int DEST_BIT  = 5;
   localparam int ADDR_HI   = 4;
   localparam logic [5:0] OP_COMPLEMENT = 6'b001001;
   localparam logic [5:0] OP_DECREMENT  = 6'b000011;
   localparam logic [5:0] OP_DEC_SKIP   = 6'b001011;
   localparam logic [11:0] NO_OPERATION = 12'h000;
   localparam logic [7:0] ZERO_BYTE     = 8'h00;
   localparam logic [7:0] ONE_BYTE      = 8'h01;
   localparam logic       DEST_WORK     = 1'b0;

   typedef enum logic [1:0] {
      CDO_NONE,
      CDO_COMPLEMENT,
      CDO_DECREMENT,
      CDO_DEC_SKIP
   } cdo_op_e;
endpackage

// *** design/cdo_file_mem.sv ***
// ***********************************************************
// File register memory, registered read, one write port
// ***********************************************************
module cdo_file_mem (
   // Clock and reset
   input  wire logic                      clock,
   input  wire logic                      rst_n,
   // Read port
   input  wire logic [cdo_pkg::ADDR_W-1:0] rd_addr,
   output logic      [cdo_pkg::DATA_W-1:0] rd_data,
   // Write port
   input  wire logic                      wr_en,
   input  wire logic [cdo_pkg::ADDR_W-1:0] wr_addr,
   input  wire logic [cdo_pkg::DATA_W-1:0] wr_data
);
   logic [cdo_pkg::DATA_W-1:0] mem_r [cdo_pkg::FILE_DEPTH];

   // Bytes are cleared by reset: the only writers are the ops themselves, which
   // cannot turn an unknown byte into a known one; costs a plain RAM macro
   for (genvar i = 0; i < cdo_pkg::FILE_DEPTH; i++) begin : g_word
      always_ff @(posedge clock) begin
         if (!rst_n) begin
            mem_r[i] <= cdo_pkg::ZERO_BYTE;
         end else if (wr_en && (wr_addr == cdo_pkg::ADDR_W'(i))) begin
            mem_r[i] <= wr_data;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rd_data <= cdo_pkg::ZERO_BYTE;
      end else begin
         rd_data <= mem_r[rd_addr];
      end
   end
endmodule

// *** design/cdo_core.sv ***
module cdo_core (
   // Clock and reset
   input  wire logic                       clock,
   input  wire logic                       rst_n,
   // Instruction stream
   input  wire logic                       instr_valid,
   input  wire logic [cdo_pkg::OPC_W-1:0]  instr,
   // Status and results
   output logic      [cdo_pkg::DATA_W-1:0] work_reg,
   output logic                            zero_flag,
   output logic                            skip_active,
   output logic                            busy,
   output logic                            done,
   output logic      [cdo_pkg::OPC_W-1:0]  exec_instr
);
   // ***********************************************************
   // Decode
   // ***********************************************************
   // Class field picks the operation; every other class is a no-effect slot
   function automatic cdo_pkg::cdo_op_e decode(input logic [cdo_pkg::OPC_W-1:0] op);
      logic [cdo_pkg::OP_HI-cdo_pkg::OP_LO:0] cls;
      cdo_pkg::cdo_op_e                       kind;
      cls = op[cdo_pkg::OP_HI:cdo_pkg::OP_LO];
      case (cls)
         cdo_pkg::OP_COMPLEMENT: begin
            kind = cdo_pkg::CDO_COMPLEMENT;
         end
         cdo_pkg::OP_DECREMENT: begin
            kind = cdo_pkg::CDO_DECREMENT;
         end
         cdo_pkg::OP_DEC_SKIP: begin
            kind = cdo_pkg::CDO_DEC_SKIP;
         end
         default: begin
            kind = cdo_pkg::CDO_NONE;
         end
      endcase
      return kind;
   endfunction

   // Plain forms write status; the skip form must leave it alone
   function automatic logic updates_zero(input cdo_pkg::cdo_op_e kind);
      return (kind == cdo_pkg::CDO_COMPLEMENT) || (kind == cdo_pkg::CDO_DECREMENT);
   endfunction

   // Recognised opcodes write a destination; unknown ones only use up the slot
   function automatic logic writes_dest(input cdo_pkg::cdo_op_e kind);
      return kind != cdo_pkg::CDO_NONE;
   endfunction

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_EXEC,
      ST_SKIP
   } cdo_state_e;

   // ***********************************************************
   // Signals
   // ***********************************************************
   cdo_state_e                  state_r;
   cdo_state_e                  state_nxt;
   logic [cdo_pkg::OPC_W-1:0]   op_r;
   logic [cdo_pkg::OPC_W-1:0]   op_nxt;
   logic [cdo_pkg::DATA_W-1:0]  work_r;
   logic [cdo_pkg::DATA_W-1:0]  work_nxt;
   logic                        zero_r;
   logic                        zero_nxt;
   logic                        done_r;
   logic                        done_nxt;
   logic [cdo_pkg::OPC_W-1:0]   exec_r;
   logic [cdo_pkg::OPC_W-1:0]   exec_nxt;
   logic [cdo_pkg::DATA_W-1:0]  file_rd;
   logic [cdo_pkg::DATA_W-1:0]  inverted;
   logic [cdo_pkg::DATA_W-1:0]  decremented;
   logic [cdo_pkg::DATA_W-1:0]  result;
   cdo_pkg::cdo_op_e            op_kind;
   logic                        in_idle;
   logic                        in_exec;
   logic                        in_skip;
   logic                        to_file;
   logic                        result_zero;
   logic                        wr_file;
   logic                        wr_work;
   logic                        wr_zero;
   logic                        squash;
   logic                        take_new;
   logic [cdo_pkg::ADDR_W-1:0]  rd_addr;
   logic [cdo_pkg::ADDR_W-1:0]  wr_addr;

   // ***********************************************************
   // Datapath
   // ***********************************************************
   // Taken only when idle; the file byte is read on the taking edge
   assign in_idle     = state_r == ST_IDLE;
   assign in_exec     = state_r == ST_EXEC;
   assign in_skip     = state_r == ST_SKIP;
   assign take_new    = instr_valid && in_idle;
   assign op_kind     = decode(op_r);
   assign to_file     = op_r[cdo_pkg::DEST_BIT] != cdo_pkg::DEST_WORK;
   assign rd_addr     = instr[cdo_pkg::ADDR_HI:0];
   assign wr_addr     = op_r[cdo_pkg::ADDR_HI:0];

   // Both results are formed; the class picks one
   assign inverted    = ~file_rd;
   assign decremented = file_rd - cdo_pkg::ONE_BYTE;
   assign result      = (op_kind == cdo_pkg::CDO_COMPLEMENT) ? inverted : decremented;
   assign result_zero = result == cdo_pkg::ZERO_BYTE;

   // Destination and status strobes, live only in the execute cycle
   assign wr_file     = in_exec && writes_dest(op_kind) && to_file;
   assign wr_work     = in_exec && writes_dest(op_kind) && !to_file;
   assign wr_zero     = in_exec && updates_zero(op_kind);
   assign squash      = in_exec && (op_kind == cdo_pkg::CDO_DEC_SKIP) && result_zero;

   assign busy        = in_exec;
   assign skip_active = in_skip;

   // Write of one op lands before the next op can be taken, so no bypass
   cdo_file_mem u_mem (
      .clock   (clock),
      .rst_n   (rst_n),
      .rd_addr (rd_addr),
      .rd_data (file_rd),
      .wr_en   (wr_file),
      .wr_addr (wr_addr),
      .wr_data (result)
   );

   // ***********************************************************
   // Sequencing
   // ***********************************************************
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (take_new) begin
               state_nxt = ST_EXEC;
            end
         end
         ST_EXEC: begin
            if (squash) begin
               state_nxt = ST_SKIP;
            end else begin
               state_nxt = ST_IDLE;
            end
         end
         ST_SKIP: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // ***********************************************************
   // Next values
   // ***********************************************************
   assign op_nxt      = take_new ? instr : op_r;
   assign work_nxt    = wr_work ? result : work_r;
   assign zero_nxt    = wr_zero ? result_zero : zero_r;
   assign done_nxt    = in_exec || in_skip;
   // Squashed slot reports a no-operation; any request in it is dropped
   assign exec_nxt    = in_exec ? op_r : (in_skip ? cdo_pkg::NO_OPERATION : exec_r);

   // Outputs straight from the flops
   assign work_reg    = work_r;
   assign zero_flag   = zero_r;
   assign done        = done_r;
   assign exec_instr  = exec_r;

   // ***********************************************************
   // Registers
   // ***********************************************************
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         op_r <= cdo_pkg::NO_OPERATION;
      end else begin
         op_r <= op_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         work_r <= cdo_pkg::ZERO_BYTE;
      end else begin
         work_r <= work_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         zero_r <= 1'b0;
      end else begin
         zero_r <= zero_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         done_r <= 1'b0;
      end else begin
         done_r <= done_nxt;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         exec_r <= cdo_pkg::NO_OPERATION;
      end else begin
         exec_r <= exec_nxt;
      end
   end
endmodule

// *** dv/cdo_checker.sv ***
// ****
// Port checks
// ****
module cdo_checker (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        instr_valid,
   input wire logic [11:0] instr,
   input wire logic [7:0]  work_reg,
   input wire logic        zero_flag,
   input wire logic        skip_active,
   input wire logic        busy,
   input wire logic        done,
   input wire logic [11:0] exec_instr
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire       tk = instr_valid && !busy && !skip_active;
   wire       w0 = tk && !instr[5];
   wire [5:0] cl = instr[11:6];
   a_take_done: assert property (tk |=> busy ##1 done && exec_instr == $past(instr, 2))
      else $error("no done after take");
   a_comp_zero: assert property (w0 && cl == cdo_pkg::OP_COMPLEMENT |=> ##1 zero_flag == (work_reg == 8'h00))
      else $error("complement zero wrong");
   a_dec_zero: assert property (w0 && cl == cdo_pkg::OP_DECREMENT |=> ##1 zero_flag == (work_reg == 8'h00))
      else $error("decrement zero wrong");
   a_skip_flag: assert property (tk && cl == cdo_pkg::OP_DEC_SKIP |=> ##1 $stable(zero_flag))
      else $error("skip form changed zero");
   a_skip_when: assert property (w0 && cl == cdo_pkg::OP_DEC_SKIP |=> ##1 skip_active == (work_reg == 8'h00))
      else $error("skip decision wrong");
   a_skip_nop: assert property (skip_active |=> done && !skip_active && exec_instr == cdo_pkg::NO_OPERATION)
      else $error("squash slot wrong");
endmodule
bind cdo_core cdo_checker u_chk (.clock, .rst_n, .instr_valid, .instr, .work_reg, .zero_flag, .skip_active,
   .busy, .done, .exec_instr);

// *** dv/testbench.sv ***
// ****
// Bench
// ****
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clock = 0, rst_n = 0, instr_valid = 0, zero_flag, skip_active, busy, done;
   logic [11:0] instr = 12'h000, exec_instr;
   logic [7:0]  work_reg;
   int          miscompares = 0, checks = 0;
   always #5 clock = ~clock;
   cdo_core dut (.clock, .rst_n, .instr_valid, .instr, .work_reg, .zero_flag, .skip_active, .busy, .done,
      .exec_instr);
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Outputs right after any reset release
   task automatic check_idle();
      chk(work_reg, 8'h00);
      chk(zero_flag, 0);
      chk(done, 0);
      chk(busy, 0);
      chk(skip_active, 0);
      chk(exec_instr, cdo_pkg::NO_OPERATION);
   endtask
   // Latency is fixed by the sequencer, so each stage is judged on its own edge
   task automatic run(input logic [11:0] op, input logic sk);
      @(posedge clock) #1;
      instr_valid = 1;
      instr = op;
      @(posedge clock) #1;
      instr_valid = 0;
      chk(busy, 1);
      chk(done, 0);
      @(posedge clock) #1;
      chk(done, 1);
      chk(busy, 0);
      chk(exec_instr, op);
      chk(skip_active, sk);
      if (sk) begin
         @(posedge clock) #1;
         chk(done, 1);
         chk(skip_active, 0);
         chk(exec_instr, cdo_pkg::NO_OPERATION);
      end
   endtask
   // Bytes start cleared, so every expected value follows from the opcodes alone
   task automatic t_arith();
      run(12'h0C3, 0);
      chk(work_reg, 8'hFF);
      chk(zero_flag, 0);
      run(12'h263, 0);
      chk(work_reg, 8'hFF);
      run(12'h243, 0);
      chk(work_reg, 8'h00);
      chk(zero_flag, 1);
      run(12'h0E3, 0);
      chk(work_reg, 8'h00);
      chk(zero_flag, 0);
      run(12'h0C3, 0);
      chk(work_reg, 8'hFD);
   endtask
   // Byte 4 is walked to one so the skip form reaches zero with the flag clear, then set
   task automatic t_skip();
      run(12'h0E4, 0);
      chk(work_reg, 8'hFD);
      run(12'h0E4, 0);
      run(12'h264, 0);
      chk(zero_flag, 0);
      run(12'h2C4, 1);
      chk(work_reg, 8'h00);
      chk(zero_flag, 0);
      t_squash();
      run(12'h0C4, 0);
      chk(work_reg, 8'h00);
      chk(zero_flag, 1);
      run(12'h2E4, 1);
      chk(work_reg, 8'h00);
      chk(zero_flag, 1);
      run(12'h2C4, 0);
      chk(work_reg, 8'hFF);
      chk(zero_flag, 1);
      run(12'h284, 0);
      chk(work_reg, 8'hFF);
      chk(zero_flag, 1);
      run(12'h2E4, 0);
      chk(work_reg, 8'hFF);
      chk(zero_flag, 1);
   endtask
   // A request held through the execute and squashed slots must be dropped
   task automatic t_squash();
      @(posedge clock) #1;
      instr_valid = 1;
      instr = 12'h2C4;
      @(posedge clock) #1;
      instr = 12'h244;
      @(posedge clock) #1;
      chk(skip_active, 1);
      chk(work_reg, 8'h00);
      @(posedge clock) #1;
      instr_valid = 0;
      chk(exec_instr, cdo_pkg::NO_OPERATION);
      chk(work_reg, 8'h00);
   endtask
   // Mid-run reset must clear results and file bytes alike
   task automatic t_reset();
      @(posedge clock) #1;
      rst_n = 0;
      repeat (2) @(posedge clock);
      #1 rst_n = 1;
      check_idle();
      run(12'h0C4, 0);
      chk(work_reg, 8'hFF);
      chk(zero_flag, 0);
   endtask
   initial begin
      repeat (2) @(posedge clock);
      #1 rst_n = 1;
      check_idle();
      t_arith();
      t_skip();
      t_reset();
      conclude();
   end
endmodule
